// [scme_pkg.sv]
// Constants and types for the system control, mode and exception block.
// Assumes a single 100 MHz clock; one settle-wait state is one clock.
package scme_pkg;
	// =========================================================
	// Register offsets and reset values
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_AREA = 3'h1;
	localparam logic [2:0] ADDR_BREL = 3'h2;
	localparam logic [2:0] ADDR_MODE = 3'h3;
	localparam logic [2:0] ADDR_VEC  = 3'h4;
	localparam logic [7:0] CTRL_RST    = 8'h09;
	localparam logic [7:0] AREA_RST_8  = 8'hff;
	localparam logic [7:0] AREA_RST_16 = 8'h00;
	localparam logic [7:0] BREL_RST    = 8'he0;
	// =========================================================
	// Field positions of system_control
	localparam int B_STANDBY_SELECT  = 7;
	localparam int B_STS_H = 6;
	localparam int B_STS_L = 4;
	localparam int B_UE    = 3;
	localparam int B_NMI_EDGE_SELECT = 2;
	localparam int B_STANDBY_BUS_DRIVE_OPTION  = 1;
	localparam int B_INTERNAL_MEMORY_ENABLE  = 0;
	// =========================================================
	// Settle-wait lengths in system clock states
	localparam int WAIT_0 = 8192;
	localparam int WAIT_1 = 16384;
	localparam int WAIT_2 = 32768;
	localparam int WAIT_3 = 65536;
	localparam int WAIT_4 = 131072;
	localparam int WAIT_5 = 262144;
	localparam int WAIT_6 = 1024;
	// =========================================================
	// Modes, vectors, reset values of helpers
	localparam logic [2:0] MODE1 = 3'h1;
	localparam logic [2:0] MODE2 = 3'h2;
	localparam logic [2:0] MODE3 = 3'h3;
	localparam logic [2:0] MODE4 = 3'h4;
	localparam logic [7:0] VEC_RESET = 8'h00;
	localparam logic [7:0] VEC_NMI   = 8'h07;
	localparam logic [7:0] VEC_TRAP0 = 8'h08;
	localparam logic [7:0] VEC_IRQ0  = 8'h0c;
	localparam logic [7:0] VEC_INT0  = 8'h14;
	localparam logic [1:0] VEC_SHIFT = 2'h2;
	localparam logic [5:0] SYNC_RST  = 6'h07;
	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_STBY, PWR_SETTLE}
		scme_pwr_t;
endpackage

// [scme_exc_if.sv]
// Requests and results between the top and the exception arbiter.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface scme_exc_if;
	logic       reset_req;
	logic       nmi_req;
	logic [5:0] irq_req;
	logic       int_req;
	logic [4:0] int_idx;
	logic       trap_req;
	logic [1:0] trap_num;
	logic       insn_done;
	logic       exc_done;
	logic       mask_ok;
	logic       run;
	logic       ue;
	logic       start;
	logic       push;
	logic       set_ui;
	logic [7:0] vector;
	logic [9:0] vec_addr;
	modport top (output reset_req, nmi_req, irq_req, int_req, int_idx,
		trap_req, trap_num, insn_done, exc_done, mask_ok, run, ue,
		input start, push, set_ui, vector, vec_addr);
	modport arb (input reset_req, nmi_req, irq_req, int_req, int_idx,
		trap_req, trap_num, insn_done, exc_done, mask_ok, run, ue,
		output start, push, set_ui, vector, vec_addr);
endinterface // scme_exc_if

// [scme_settle_timer.sv]
// Counts settle-wait states after a wake-up from software standby.
// Assumes start is a one-cycle pulse and limit is at least one.
`timescale 1ns/10ps
module scme_settle_timer (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        start_in,
	input  wire logic [18:0] limit_in,
	output logic             busy_out,
	output logic             done_out
);
	logic [18:0] cnt_reg;
	// =========================================================
	// Counter
	assign done_out = busy_out && (cnt_reg == limit_in - 19'h00001);
	always_ff @(posedge clk_in)
	begin
		if (rst_in || start_in)
			cnt_reg <= 19'h00000;
		else if (busy_out)
			cnt_reg <= cnt_reg + 19'h00001;
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			busy_out <= 1'b0;
		else if (start_in)
			busy_out <= 1'b1;
		else if (done_out)
			busy_out <= 1'b0;
	end
endmodule // scme_settle_timer

// [scme_exc_arbiter.sv]
// Orders reset, interrupt and trap exceptions and issues vectors.
// Assumes the CPU pulses insn_done and exc_done on the system clock.
`timescale 1ns/10ps
module scme_exc_arbiter
	import scme_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	scme_exc_if.arb   ex
);
	logic       nmi_pend_reg;
	logic       trap_pend_reg;
	logic [1:0] trap_num_reg;
	logic       busy_reg;
	logic       armed_reg;
	logic [2:0] irq_first;
	logic [7:0] vec_next;
	// =========================================================
	// Selection
	// No interrupt taken before the first instruction: stack not set up yet
	wire boundary  = ex.insn_done || (busy_reg && ex.exc_done);
	wire int_ok    = boundary && armed_reg && ex.run && !ex.reset_req;
	wire any_mask  = (|ex.irq_req) || ex.int_req;
	wire take_nmi  = int_ok && nmi_pend_reg;
	wire take_irq  = int_ok && ex.mask_ok && any_mask && !nmi_pend_reg;
	wire take_int  = take_nmi || take_irq;
	wire take_trap = trap_pend_reg && ex.run && !busy_reg && !take_int
		&& !ex.reset_req;
	always_comb
	begin
		irq_first = 3'h0;
		for (int i = 5; i >= 0; i--)
			if (ex.irq_req[i])
				irq_first = 3'(i);
	end
	assign vec_next = ex.reset_req ? VEC_RESET :
		take_nmi ? VEC_NMI :
		(take_irq && |ex.irq_req) ? VEC_IRQ0 + {5'h00, irq_first} :
		take_irq ? VEC_INT0 + {3'h0, ex.int_idx} :
		VEC_TRAP0 + {6'h00, trap_num_reg};
	// =========================================================
	// Pending and progress state; a new event beats its clear
	always_ff @(posedge clk_in)
	begin
		if (rst_in || ex.reset_req)
			nmi_pend_reg <= 1'b0;
		else
			nmi_pend_reg <= ex.nmi_req || (nmi_pend_reg && !take_nmi);
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in || ex.reset_req)
			trap_pend_reg <= 1'b0;
		else if (ex.trap_req)
			trap_pend_reg <= 1'b1;
		else if (take_trap)
			trap_pend_reg <= 1'b0;
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			trap_num_reg <= 2'h0;
		else if (ex.trap_req)
			trap_num_reg <= ex.trap_num;
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in || ex.reset_req)
			armed_reg <= 1'b0;
		else if (ex.insn_done)
			armed_reg <= 1'b1;
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			busy_reg <= 1'b0;
		else if (ex.reset_req || take_int || take_trap)
			busy_reg <= 1'b1;
		else if (ex.exc_done)
			busy_reg <= 1'b0;
	end
	// =========================================================
	// Results
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ex.start    <= 1'b0;
			ex.push     <= 1'b0;
			ex.set_ui   <= 1'b0;
			ex.vector   <= VEC_RESET;
			ex.vec_addr <= 10'h000;
		end
		else
		begin
			ex.start    <= ex.reset_req || take_int || take_trap;
			ex.push     <= !ex.reset_req && (take_int || take_trap);
			ex.set_ui   <= !ex.reset_req && (take_int || take_trap)
				&& !ex.ue;
			ex.vector   <= vec_next;
			ex.vec_addr <= {vec_next, 2'h0};
		end
	end
	// =========================================================
	// Checks
	property p_reset_first;
		@(posedge clk_in) disable iff (rst_in)
		ex.reset_req |=> ex.start && ex.vector == VEC_RESET && !ex.push;
	endproperty
	a_reset_first: assert property (p_reset_first)
		else $error("reset exception not started at once");
	property p_int_over_trap;
		@(posedge clk_in) disable iff (rst_in)
		take_int && trap_pend_reg |=> ex.vector != VEC_TRAP0
			&& ex.push ##1 trap_pend_reg;
	endproperty
	a_int_over_trap: assert property (p_int_over_trap)
		else $error("trap served before interrupt");
	property p_int_at_boundary;
		@(posedge clk_in) disable iff (rst_in)
		ex.start && ex.vector == VEC_NMI |->
			$past(ex.insn_done) || $past(ex.exc_done);
	endproperty
	a_int_at_boundary: assert property (p_int_at_boundary)
		else $error("interrupt taken mid instruction");
	property p_trap_push;
		@(posedge clk_in) disable iff (rst_in)
		take_trap |=> ex.push && ex.vec_addr == {ex.vector, 2'h0};
	endproperty
	a_trap_push: assert property (p_trap_push)
		else $error("trap without stack push");
	c_nmi: cover property (@(posedge clk_in) take_nmi);
	c_trap: cover property (@(posedge clk_in) take_trap);
endmodule // scme_exc_arbiter

// [scme_top.sv]
// System control register, operating mode and power-down control.
// Assumes the CPU and interrupt controller share clk_in; board pins
// (mode, chip init, hardware standby, NMI) are asynchronous.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module scme_top
	import scme_pkg::*;
#(
	parameter int WAIT_T0 = WAIT_0,
	parameter int WAIT_T1 = WAIT_1,
	parameter int WAIT_T2 = WAIT_2,
	parameter int WAIT_T3 = WAIT_3,
	parameter int WAIT_T4 = WAIT_4,
	parameter int WAIT_T5 = WAIT_5
)(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [2:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [2:0] mode_pins_in,
	input  wire logic       chip_init_n_in,
	input  wire logic       hw_standby_n_in,
	input  wire logic       nmi_pin_in,
	input  wire logic       sleep_exec_in,
	input  wire logic       wake_irq_in,
	input  wire logic       insn_done_in,
	input  wire logic       exc_done_in,
	input  wire logic       ccr_i_in,
	input  wire logic       ccr_ui_in,
	input  wire logic [5:0] irq_req_in,
	input  wire logic       int_req_in,
	input  wire logic [4:0] int_idx_in,
	input  wire logic       trap_req_in,
	input  wire logic [1:0] trap_num_in,
	output logic      [7:0] reg_rdata_out,
	output logic            cpu_halt_out,
	output logic            modules_halt_out,
	output logic            addr_oe_out,
	output logic            ctrl_oe_out,
	output logic            ctrl_high_out,
	output logic            ram_enable_out,
	output logic            ui_is_mask_out,
	output logic            mode_valid_out,
	output logic            addr_16m_out,
	output logic            a20_enable_out,
	output logic            a23_21_enable_out,
	output logic            bus16_out,
	output logic            port4_data_out,
	output logic            exc_start_out,
	output logic      [7:0] exc_vector_out,
	output logic      [9:0] exc_vec_addr_out,
	output logic            exc_push_out,
	output logic            exc_set_ui_out
);
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic       init_prev_reg;
	logic       nmi_prev_reg;
	logic [2:0] mode_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] area_reg;
	logic [7:0] brel_reg;
	scme_pwr_t  pwr_reg;
	scme_pwr_t  pwr_next;
	logic       settle_busy;
	logic       settle_done;
	logic [18:0] settle_limit;
	logic [7:0] rd_mux;
	logic [18:0] settle_cyc_reg;
	scme_exc_if ex ();

	// =========================================================
	// Pin synchronisers, no reset on the data path
	always_ff @(posedge clk_in)
	begin
		sync1_reg <= {mode_pins_in, chip_init_n_in, hw_standby_n_in,
			nmi_pin_in};
		sync2_reg <= sync1_reg;
	end
	wire [2:0] mode_s = sync2_reg[5:3];
	wire       init_s = sync2_reg[2];
	wire       stby_s = sync2_reg[1];
	wire       nmi_s  = sync2_reg[0];
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			init_prev_reg <= SYNC_RST[2];
			nmi_prev_reg  <= SYNC_RST[0];
		end
		else
		begin
			init_prev_reg <= init_s;
			nmi_prev_reg  <= nmi_s;
		end
	end

	// =========================================================
	// Decode
	wire init_rise = init_s && !init_prev_reg;
	wire hold_rst  = rst_in || !init_s || !stby_s;
	wire nmi_edge  = ctrl_reg[B_NMI_EDGE_SELECT] ? (nmi_s && !nmi_prev_reg)
		: (!nmi_s && nmi_prev_reg);
	wire [2:0] sts = ctrl_reg[B_STS_H:B_STS_L];
	wire standby_select      = ctrl_reg[B_STANDBY_SELECT];
	wire standby_bus_drive_option      = ctrl_reg[B_STANDBY_BUS_DRIVE_OPTION];
	wire ue        = ctrl_reg[B_UE];
	wire wide_s    = (mode_s == MODE2) || (mode_s == MODE4);
	wire m_valid   = (mode_reg >= MODE1) && (mode_reg <= MODE4);
	wire m_16m     = (mode_reg == MODE3) || (mode_reg == MODE4);
	wire bus16     = !(&area_reg);
	wire a_hi_en   = m_16m && (brel_reg[7:5] == 3'h0);
	wire stby_bus  = (pwr_reg == PWR_STBY) || (pwr_reg == PWR_SETTLE);
	wire wake_ext  = wake_irq_in || nmi_edge;
	wire wake_any  = wake_ext || (|irq_req_in) || int_req_in;
	wire wr_ctrl   = reg_wr_in && (reg_addr_in == ADDR_CTRL);
	wire wr_area   = reg_wr_in && (reg_addr_in == ADDR_AREA);
	wire wr_brel   = reg_wr_in && (reg_addr_in == ADDR_BREL);
	wire settle_go = (pwr_reg == PWR_STBY) && wake_ext;
	// Code 111 is illegal; it falls back on WAIT_T5, the wait of code 101
	assign settle_limit =
		(sts == 3'h0) ? 19'(WAIT_T0) :
		(sts == 3'h1) ? 19'(WAIT_T1) :
		(sts == 3'h2) ? 19'(WAIT_T2) :
		(sts == 3'h3) ? 19'(WAIT_T3) :
		(sts == 3'h4) ? 19'(WAIT_T4) :
		(sts == 3'h6) ? 19'(WAIT_6) : 19'(WAIT_T5);
	assign rd_mux =
		(reg_addr_in == ADDR_CTRL) ? ctrl_reg :
		(reg_addr_in == ADDR_AREA) ? area_reg :
		(reg_addr_in == ADDR_BREL) ? brel_reg :
		(reg_addr_in == ADDR_MODE) ?
			{m_valid, bus16, m_16m, a_hi_en, 1'b0, mode_reg} :
		(reg_addr_in == ADDR_VEC) ? ex.vector : 8'h00;

	// =========================================================
	// Mode capture, only while the chip is held in reset
	always_ff @(posedge clk_in)
	begin
		if (rst_in || !init_s)
			mode_reg <= mode_s;
	end

	// =========================================================
	// Registers; none of them clear in software standby
	always_ff @(posedge clk_in)
	begin
		if (hold_rst)
			ctrl_reg <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_reg <= reg_wdata_in;
		else if (init_rise)
			ctrl_reg[B_INTERNAL_MEMORY_ENABLE] <= 1'b1;
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in || !init_s)
			area_reg <= wide_s ? AREA_RST_16 : AREA_RST_8;
		else if (wr_area)
			area_reg <= reg_wdata_in;
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in || !init_s)
			brel_reg <= BREL_RST;
		else if (wr_brel)
			brel_reg <= reg_wdata_in;
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			reg_rdata_out <= 8'h00;
		else
			reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
	end

	// =========================================================
	// Power-down sequencing
	always_comb
	begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			PWR_RUN:
				if (sleep_exec_in)
					pwr_next = standby_select ? PWR_STBY : PWR_SLEEP;
			PWR_SLEEP:
				if (wake_any)
					pwr_next = PWR_RUN;
			PWR_STBY:
				if (wake_ext)
					pwr_next = PWR_SETTLE;
			PWR_SETTLE:
				if (settle_done)
					pwr_next = PWR_RUN;
			default:
				pwr_next = PWR_RUN;
		endcase
	end
	always_ff @(posedge clk_in)
	begin
		if (hold_rst)
			pwr_reg <= PWR_RUN;
		else
			pwr_reg <= pwr_next;
	end

	scme_settle_timer u_settle (
		.clk_in   (clk_in),
		.rst_in   (hold_rst),
		.start_in (settle_go),
		.limit_in (settle_limit),
		.busy_out (settle_busy),
		.done_out (settle_done)
	);

	// =========================================================
	// Exception ordering
	assign ex.reset_req = init_rise && stby_s;
	assign ex.nmi_req   = nmi_edge;
	assign ex.irq_req   = irq_req_in;
	assign ex.int_req   = int_req_in;
	assign ex.int_idx   = int_idx_in;
	assign ex.trap_req  = trap_req_in;
	assign ex.trap_num  = trap_num_in;
	assign ex.insn_done = insn_done_in;
	assign ex.exc_done  = exc_done_in;
	// With user_bit_enable low the user bit masks as well
	assign ex.mask_ok   = !ccr_i_in && (ue || !ccr_ui_in);
	assign ex.run       = (pwr_reg == PWR_RUN);
	assign ex.ue        = ue;

	scme_exc_arbiter u_arb (
		.clk_in (clk_in),
		.rst_in (hold_rst),
		.ex     (ex)
	);
	assign exc_start_out    = ex.start;
	assign exc_vector_out   = ex.vector;
	assign exc_vec_addr_out = ex.vec_addr;
	assign exc_push_out     = ex.push;
	assign exc_set_ui_out   = ex.set_ui;

	// =========================================================
	// Registered outputs
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cpu_halt_out     <= 1'b0;
			modules_halt_out <= 1'b0;
			addr_oe_out      <= 1'b1;
			ctrl_oe_out      <= 1'b1;
			ctrl_high_out    <= 1'b0;
		end
		else
		begin
			cpu_halt_out     <= (pwr_reg != PWR_RUN);
			modules_halt_out <= stby_bus;
			addr_oe_out      <= !stby_bus || standby_bus_drive_option;
			ctrl_oe_out      <= !stby_bus || standby_bus_drive_option;
			ctrl_high_out    <= stby_bus && standby_bus_drive_option;
		end
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ram_enable_out    <= CTRL_RST[B_INTERNAL_MEMORY_ENABLE];
			ui_is_mask_out    <= !CTRL_RST[B_UE];
			mode_valid_out    <= 1'b0;
			addr_16m_out      <= 1'b0;
			a20_enable_out    <= 1'b0;
			a23_21_enable_out <= 1'b0;
			bus16_out         <= 1'b0;
			port4_data_out    <= 1'b0;
		end
		else
		begin
			ram_enable_out    <= ctrl_reg[B_INTERNAL_MEMORY_ENABLE];
			ui_is_mask_out    <= !ue;
			mode_valid_out    <= m_valid;
			addr_16m_out      <= m_16m;
			a20_enable_out    <= m_16m;
			a23_21_enable_out <= a_hi_en;
			bus16_out         <= bus16;
			port4_data_out    <= bus16;
		end
	end

	// =========================================================
	// Checks
	always_ff @(posedge clk_in)
	begin
		if (pwr_reg == PWR_STBY)
			settle_cyc_reg <= 19'h00001;
		else if (pwr_reg == PWR_SETTLE)
			settle_cyc_reg <= settle_cyc_reg + 19'h00001;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (hold_rst);

	property p_ctrl_reset;
		@(posedge clk_in) disable iff (rst_in)
		!stby_s |=> ctrl_reg == CTRL_RST;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset)
		else $error("system_control not at reset value");
	property p_sleep_sel;
		pwr_reg == PWR_RUN && sleep_exec_in |=>
			pwr_reg == ($past(standby_select) ? PWR_STBY : PWR_SLEEP);
	endproperty
	a_sleep_sel: assert property (p_sleep_sel)
		else $error("wrong low-power state entered");
	property p_settle_len;
		pwr_reg == PWR_SETTLE && settle_done |->
			settle_cyc_reg == settle_limit ##1 pwr_reg == PWR_RUN;
	endproperty
	a_settle_len: assert property (p_settle_len)
		else $error("settle wait length wrong");
	property p_stby_hold;
		pwr_reg == PWR_STBY && !wake_ext |=> pwr_reg == PWR_STBY;
	endproperty
	a_stby_hold: assert property (p_stby_hold)
		else $error("standby left without wake-up");
	property p_bus_drive;
		stby_bus ##1 stby_bus |-> addr_oe_out == $past(standby_bus_drive_option)
			&& ctrl_high_out == $past(standby_bus_drive_option);
	endproperty
	a_bus_drive: assert property (p_bus_drive)
		else $error("standby bus drive wrong");
	property p_bus_width;
		##1 1'b1 |-> bus16_out == !(&$past(area_reg))
			&& port4_data_out == bus16_out;
	endproperty
	a_bus_width: assert property (p_bus_width)
		else $error("bus width not per area settings");
	property p_addr_hi;
		a23_21_enable_out |-> $past(m_16m)
			&& $past(brel_reg[7:5]) == 3'h0;
	endproperty
	a_addr_hi: assert property (p_addr_hi)
		else $error("upper address pins enabled too early");
	property p_nmi_edge;
		!ctrl_reg[B_NMI_EDGE_SELECT] && nmi_prev_reg && !nmi_s |-> nmi_edge;
	endproperty
	a_nmi_edge: assert property (p_nmi_edge)
		else $error("falling NMI edge missed");
	property p_ram_rise;
		init_rise && !wr_ctrl |=> ctrl_reg[B_INTERNAL_MEMORY_ENABLE] ##1 ram_enable_out;
	endproperty
	a_ram_rise: assert property (p_ram_rise)
		else $error("RAM enable not set on init release");
	c_sleep: cover property (pwr_reg == PWR_SLEEP ##1 pwr_reg == PWR_RUN);
	c_settle: cover property (pwr_reg == PWR_SETTLE && settle_done);
	c_bus16: cover property ($rose(bus16_out));
endmodule // scme_top

// [scme_tb.sv]
// Self-checking bench for the system control, mode and exception block.
// Assumes mode 1 on the pins, mode 3 after the chip init scenario,
// and shortened settle-wait parameters.
`timescale 1ns/10ps
module testbench
	import scme_pkg::*;
;
	// ==========================================================
	// Signals
	logic       clk_in = '0, rst_in = '1, reg_wr_in = '0, reg_rd_in = '0;
	logic [2:0] reg_addr_in = '0, mode_pins_in = 3'h1;
	logic [7:0] reg_wdata_in = '0, reg_rdata_out, exc_vector_out, d;
	// NMI pin idles high, matching the edge detector's value after reset
	logic       chip_init_n_in = '1, hw_standby_n_in = '1, nmi_pin_in = '1;
	logic       sleep_exec_in = '0, wake_irq_in = '0, insn_done_in = '0;
	logic       exc_done_in = '0, ccr_i_in = '1, ccr_ui_in = '1;
	logic       int_req_in = '0, trap_req_in = '0;
	logic [5:0] irq_req_in = '0;
	logic [4:0] int_idx_in = '0;
	logic [1:0] trap_num_in = '0;
	logic [9:0] exc_vec_addr_out;
	logic       cpu_halt_out, modules_halt_out, addr_oe_out, ctrl_oe_out;
	logic       ctrl_high_out, ram_enable_out, ui_is_mask_out, mode_valid_out;
	logic       addr_16m_out, a20_enable_out, a23_21_enable_out, bus16_out;
	logic       port4_data_out, exc_start_out, exc_push_out, exc_set_ui_out;
	int         errors = 0, n_checks = 0;
	bit         got;

	scme_top #(.WAIT_T0(16), .WAIT_T1(20), .WAIT_T2(24), .WAIT_T3(28),
		.WAIT_T4(32), .WAIT_T5(36)) u_dut (.clk_in, .rst_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .mode_pins_in, .chip_init_n_in,
		.hw_standby_n_in, .nmi_pin_in, .sleep_exec_in, .wake_irq_in,
		.insn_done_in, .exc_done_in, .ccr_i_in, .ccr_ui_in, .irq_req_in,
		.int_req_in, .int_idx_in, .trap_req_in, .trap_num_in, .reg_rdata_out,
		.cpu_halt_out, .modules_halt_out, .addr_oe_out, .ctrl_oe_out,
		.ctrl_high_out, .ram_enable_out, .ui_is_mask_out, .mode_valid_out,
		.addr_16m_out, .a20_enable_out, .a23_21_enable_out, .bus16_out,
		.port4_data_out, .exc_start_out, .exc_vector_out, .exc_vec_addr_out,
		.exc_push_out, .exc_set_ui_out);

	always #5 clk_in = ~clk_in;

	// ==========================================================
	// Shared tasks
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string s, input logic [9:0] v, input logic [9:0] e);
		n_checks++;
		if (v !== e)
		begin
			errors++;
			$display("[FAIL] %s exp %h seen %h", s, e, v);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask

	// Pulses {exc_done, trap, insn_done}, then polls a bounded while
	task fire(input logic [2:0] m, input bit need);
		int i;
		@(posedge clk_in);
		{exc_done_in, trap_req_in, insn_done_in} <= m;
		got = 0;
		for (i = 0; i < 12 && !got; i++)
		begin
			@(posedge clk_in);
			{exc_done_in, trap_req_in, insn_done_in} <= 3'h0;
			#1 got = exc_start_out;
		end
		if (need && !got)
		begin
			errors++;
			give_verdict;
		end
	endtask

	task vchk(input logic [7:0] v, input logic p);
		chk("vector", exc_vector_out, v);
		chk("vec addr", exc_vec_addr_out, {v, 2'h0});
		chk("push", exc_push_out, p);
	endtask

	// ==========================================================
	// Scenarios
	task t_regs;
		rd(ADDR_CTRL, d);
		chk("ctrl rst", d, CTRL_RST);
		rd(ADDR_AREA, d);
		chk("area rst", d, AREA_RST_8);
		rd(ADDR_BREL, d);
		chk("brel rst", d, BREL_RST);
		chk("ram", ram_enable_out, 1'b1);
		chk("bus16", bus16_out, 1'b0);
		chk("a20", a20_enable_out, 1'b0);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_AREA, 8'hfe);
		tick(2);
		chk("ui mask", ui_is_mask_out, 1'b1);
		chk("ram off", ram_enable_out, 1'b0);
		chk("bus16 on", bus16_out, 1'b1);
		chk("port4", port4_data_out, 1'b1);
		$display("test registers done");
	endtask

	task t_exc;
		wr(ADDR_CTRL, 8'h05);
		fire(3'h1, 0);
		chk("idle", got, 1'b0);
		trap_num_in <= 2'h3;
		fire(3'h2, 1);
		vchk(8'h0b, 1'b1);
		chk("set ui", exc_set_ui_out, 1'b1);
		fire(3'h4, 0);
		irq_req_in <= 6'h06;
		ccr_i_in <= 1'b0;
		ccr_ui_in <= 1'b0;
		fire(3'h0, 0);
		chk("early", got, 1'b0);
		fire(3'h1, 1);
		vchk(8'h0d, 1'b1);
		irq_req_in <= 6'h00;
		int_req_in <= 1'b1;
		int_idx_in <= 5'h03;
		fire(3'h4, 1);
		vchk(8'h17, 1'b1);
		ccr_i_in <= 1'b1;
		int_req_in <= 1'b0;
		fire(3'h4, 0);
		// Falling edge is ignored while the rising edge is selected
		nmi_pin_in <= 1'b0;
		trap_num_in <= 2'h0;
		tick(4);
		nmi_pin_in <= 1'b1;
		tick(4);
		fire(3'h3, 1);
		vchk(8'h07, 1'b1);
		fire(3'h4, 1);
		vchk(8'h08, 1'b1);
		fire(3'h4, 0);
		$display("test exceptions done");
	endtask

	task t_stby(input logic [7:0] c, input int n);
		int i;
		wr(ADDR_CTRL, c);
		@(posedge clk_in);
		sleep_exec_in <= 1'b1;
		@(posedge clk_in);
		sleep_exec_in <= 1'b0;
		tick(3);
		chk("halt", cpu_halt_out, 1'b1);
		chk("mod halt", modules_halt_out, c[7]);
		if (c[7])
		begin
			chk("addr oe", addr_oe_out, c[1]);
			chk("ctrl oe", ctrl_oe_out, c[1]);
			chk("ctrl high", ctrl_high_out, c[1]);
		end
		// Falling NMI wakes when bit 4 is set; sync adds two cycles
		@(posedge clk_in);
		if (c[4])
			nmi_pin_in <= 1'b0;
		else
			wake_irq_in <= 1'b1;
		@(posedge clk_in);
		wake_irq_in <= 1'b0;
		#1;
		for (i = 0; i < n + 40 && cpu_halt_out; i++)
			tick(1);
		nmi_pin_in <= 1'b1;
		chk("wait", i >= n && i <= n + 4, 1'b1);
		if (cpu_halt_out)
			give_verdict;
		rd(ADDR_CTRL, d);
		chk("ctrl kept", d, c);
		$display("test standby %0d done", n);
	endtask

	task t_init;
		wr(ADDR_CTRL, 8'h00);
		@(posedge clk_in);
		chip_init_n_in <= 1'b0;
		mode_pins_in <= 3'h3;
		tick(12);
		@(posedge clk_in);
		chip_init_n_in <= 1'b1;
		fire(3'h0, 1);
		vchk(8'h00, 1'b0);
		rd(ADDR_CTRL, d);
		chk("ctrl init", d, CTRL_RST);
		chk("a20", a20_enable_out, 1'b1);
		chk("16m", addr_16m_out, 1'b1);
		chk("valid", mode_valid_out, 1'b1);
		chk("a23 off", a23_21_enable_out, 1'b0);
		rd(ADDR_MODE, d);
		chk("mode", d, 8'ha3);
		wr(ADDR_BREL, 8'h00);
		tick(2);
		chk("a23 on", a23_21_enable_out, 1'b1);
		wr(ADDR_CTRL, 8'h00);
		@(posedge clk_in);
		hw_standby_n_in <= 1'b0;
		tick(6);
		@(posedge clk_in);
		hw_standby_n_in <= 1'b1;
		tick(4);
		rd(ADDR_CTRL, d);
		chk("ctrl hw stby", d, CTRL_RST);
		$display("test chip init done");
	endtask

	initial
	begin
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		t_regs;
		t_exc;
		t_stby(8'h0b, 0);
		t_stby(8'h83, 16);
		t_stby(8'hd8, 36);
		// Code 110 takes the unshortened WAIT_6 of 1024 states, which has no parameter
		t_stby(8'he9, 1024);
		t_init;
		give_verdict;
	end
endmodule // testbench
